// ===== verilog/dsp_accumulator_pkg.sv
// constants and operation codes for the dsp accumulator unit
// Operation
// - one 64-bit accumulator register is the working store for dsp instructions
// - multiply and multiply-accumulate instructions update the accumulator with their result
// - write-high loads a 32-bit value into bits 63..32, rest kept
// - write-low loads a 32-bit value into bits 31..0, upper bits kept
// - read-high returns bits 63..32, accumulator unchanged
// - read-middle returns bits 47..16, accumulator unchanged
`default_nettype none
package dsp_accumulator_pkg;
  // ****************************************
  // widths and positions
  // ****************************************
  localparam int unsigned ACC_W     = 64;
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned HIGH_LSB  = 32;
  localparam int unsigned MID_LSB   = 16;
  localparam logic [63:0] ACC_RESET = 64'h0;
  localparam int unsigned OP_W      = 4;

  // ****************************************
  // operation codes
  // ****************************************
  localparam logic [3:0] OP_NONE                         = 4'h0;
  localparam logic [3:0] OP_SIGNED_WIDE_MULTIPLY         = 4'h1;
  localparam logic [3:0] OP_UNSIGNED_WIDE_MULTIPLY       = 4'h2;
  localparam logic [3:0] OP_FIXED_POINT_MULTIPLY         = 4'h3;
  localparam logic [3:0] OP_PLAIN_MULTIPLY               = 4'h4;
  localparam logic [3:0] OP_REPEATED_MULTIPLY_ACCUMULATE = 4'h5;
  localparam logic [3:0] OP_WRITE_ACC_HIGH               = 4'h6;
  localparam logic [3:0] OP_WRITE_ACC_LOW                = 4'h7;
  localparam logic [3:0] OP_READ_ACC_HIGH                = 4'h8;
  localparam logic [3:0] OP_READ_ACC_MIDDLE              = 4'h9;
endpackage
`default_nettype wire

// ===== verilog/dsp_accumulator_unit.sv
// dsp accumulator register with slice moves and multiply update path
`timescale 1ns/1ps
`default_nettype none
module dsp_accumulator_unit #(
  // accumulator and general-register widths
  parameter int unsigned ACC_W    = dsp_accumulator_pkg::ACC_W,
  parameter int unsigned WORD_W   = dsp_accumulator_pkg::WORD_W,
  // slice positions for the read moves
  parameter int unsigned HIGH_LSB = dsp_accumulator_pkg::HIGH_LSB,
  parameter int unsigned MID_LSB  = dsp_accumulator_pkg::MID_LSB
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // instruction issue
  input  wire logic              op_valid,
  input  wire logic [3:0]        op_code,
  input  wire logic [WORD_W-1:0] gpr_wdata,
  input  wire logic [ACC_W-1:0]  mult_result,
  // results
  output logic                   rd_valid,
  output logic [WORD_W-1:0]      rd_data,
  output logic [ACC_W-1:0]       acc_value
);
  // ****************************************
  // parameter checks
  // ****************************************
  // the lane split below assumes exactly two word lanes
  if (ACC_W != 2 * WORD_W) begin : g_bad_acc_w
    $error("accumulator must be exactly two words wide");
  end

  // write-high and read-high share the upper lane boundary
  if (HIGH_LSB != WORD_W) begin : g_bad_high_lsb
    $error("high slice must start at the upper lane");
  end

  // middle slice must lie wholly inside the accumulator
  if (MID_LSB + WORD_W > ACC_W) begin : g_bad_mid_lsb
    $error("middle slice runs past the accumulator");
  end

  // reset constant is held at the documented width
  if (ACC_W != $bits(dsp_accumulator_pkg::ACC_RESET)) begin : g_bad_reset_w
    $error("reset value width differs from accumulator width");
  end

  // ****************************************
  // local constants
  // ****************************************
  localparam int unsigned LANES     = 2;
  localparam int unsigned HIGH_LANE = 1;
  localparam int unsigned LOW_LANE  = 0;

  // ****************************************
  // operation decode
  // ****************************************
  // all five multiply kinds share one load path
  function automatic logic is_mult(input logic [3:0] c);
    is_mult = (c == dsp_accumulator_pkg::OP_SIGNED_WIDE_MULTIPLY) ||
              (c == dsp_accumulator_pkg::OP_UNSIGNED_WIDE_MULTIPLY) ||
              (c == dsp_accumulator_pkg::OP_FIXED_POINT_MULTIPLY) ||
              (c == dsp_accumulator_pkg::OP_PLAIN_MULTIPLY) ||
              (c == dsp_accumulator_pkg::OP_REPEATED_MULTIPLY_ACCUMULATE);
  endfunction

  function automatic logic is_write_high(input logic [3:0] c);
    is_write_high = (c == dsp_accumulator_pkg::OP_WRITE_ACC_HIGH);
  endfunction

  function automatic logic is_write_low(input logic [3:0] c);
    is_write_low = (c == dsp_accumulator_pkg::OP_WRITE_ACC_LOW);
  endfunction

  function automatic logic is_read_high(input logic [3:0] c);
    is_read_high = (c == dsp_accumulator_pkg::OP_READ_ACC_HIGH);
  endfunction

  function automatic logic is_read_mid(input logic [3:0] c);
    is_read_mid = (c == dsp_accumulator_pkg::OP_READ_ACC_MIDDLE);
  endfunction

  // either read move
  function automatic logic is_read(input logic [3:0] c);
    is_read = is_read_high(c) || is_read_mid(c);
  endfunction

  // picks the word a read move returns
  function automatic logic [WORD_W-1:0] read_slice(
    input logic [ACC_W-1:0] acc,
    input logic             take_mid
  );
    if (take_mid) begin
      read_slice = acc[MID_LSB +: WORD_W];
    end else begin
      read_slice = acc[HIGH_LSB +: WORD_W];
    end
  endfunction

  // ****************************************
  // issue qualifiers
  // ****************************************
  // codes 0 and 10 to 15 match none of these and are dropped silently
  logic take_mult;
  logic take_write_high;
  logic take_write_low;
  logic take_read;
  logic take_read_mid;

  assign take_mult       = op_valid && is_mult(op_code);
  assign take_write_high = op_valid && is_write_high(op_code);
  assign take_write_low  = op_valid && is_write_low(op_code);
  assign take_read       = op_valid && is_read(op_code);
  assign take_read_mid   = op_valid && is_read_mid(op_code);

  // ****************************************
  // accumulator lanes
  // ****************************************
  // one 64-bit working store, kept as two word lanes
  wire logic [ACC_W-1:0] dsp_accumulator;

  for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
    logic              lane_write;
    logic [WORD_W-1:0] lane_d;
    logic [WORD_W-1:0] lane_q;

    if (lane == HIGH_LANE) begin : g_high
      assign lane_write = take_write_high;
    end else begin : g_low
      assign lane_write = take_write_low;
    end

    // multiply result arrives whole; the sum for accumulate is made upstream
    always_comb begin
      lane_d = lane_q;
      if (take_mult) begin
        lane_d = mult_result[lane*WORD_W +: WORD_W];
      end else if (lane_write) begin
        lane_d = gpr_wdata;
      end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        lane_q <= dsp_accumulator_pkg::ACC_RESET[lane*WORD_W +: WORD_W];
      end else begin
        lane_q <= lane_d;
      end
    end

    assign dsp_accumulator[lane*WORD_W +: WORD_W] = lane_q;
  end

  // ****************************************
  // read valid
  // ****************************************
  // one-cycle pulse, one edge after the read is taken
  logic rd_valid_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= take_read;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // sampled from the old value, so a read beside a write returns pre-write data;
  // held until the next read so a slow consumer can still pick it up
  logic [WORD_W-1:0] rd_data_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= '0;
    end else if (take_read) begin
      rd_data_q <= read_slice(dsp_accumulator, take_read_mid);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // reads never touch the lanes, so the accumulator is left as it was
  assign rd_valid  = rd_valid_q;
  assign rd_data   = rd_data_q;
  assign acc_value = dsp_accumulator;

  // ****************************************
  // notes for users
  // ****************************************
  // no back-pressure: a new operation may be issued on every edge;
  // a multiply and a write in one cycle cannot happen, one code per cycle;
  // limitation: there is no saturation or rounding here, the multiplier
  // side must hand over the final 64-bit value it wants stored;
  // trade-off: the lanes are split so a half write touches only one lane's
  // enable, at the cost of a little more decode
endmodule // dsp_accumulator_unit
`default_nettype wire

// ===== bench/dsp_accumulator_props.sv
// checker for the dsp accumulator unit
`timescale 1ns/1ps
`default_nettype none
module acc_props(input wire logic sys_clk,nrst,op_valid,input wire logic [3:0] op_code,
  input wire logic [31:0] gpr_wdata,input wire logic [63:0] mult_result,
  input wire logic rd_valid,input wire logic [31:0] rd_data,input wire logic [63:0] acc_value);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  mul_load_a: assert property (op_valid&&op_code inside {[1:5]} |=> acc_value==$past(mult_result)) else $error("mul");
  wr_high_a: assert property (op_valid&&op_code==4'h6 |=> acc_value=={$past(gpr_wdata),$past(acc_value[31:0])}) else $error("wh");
  wr_low_a: assert property (op_valid&&op_code==4'h7 |=> acc_value=={$past(acc_value[63:32]),$past(gpr_wdata)}) else $error("wl");
  rd_high_a: assert property (op_valid&&op_code==4'h8 |=> rd_valid&&rd_data==$past(acc_value[63:32])&&$stable(acc_value)) else $error("rh");
  rd_mid_a: assert property (op_valid&&op_code==4'h9 |=> rd_valid&&rd_data==$past(acc_value[47:16])&&$stable(acc_value)) else $error("rm");
  acc_hold_a: assert property (!(op_valid&&op_code inside {[1:7]}) |=> $stable(acc_value)) else $error("hold");
  cover property (op_valid&&op_code==4'h5);
  cover property (op_valid&&op_code==4'h9);
  cover property (op_valid&&op_code==4'hf);
endmodule // acc_props
bind dsp_accumulator_unit acc_props u_props(.*);
`default_nettype wire

// ===== bench/testbench.sv
// random and corner-case bench for the dsp accumulator unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk=0,nrst=0,op_valid=0,rd_valid;
  logic [3:0] op_code=0;
  logic [31:0] gpr_wdata=0,rd_data,x;
  logic [63:0] mult_result=0,acc_value,m=0;
  int bad_count=0,total_checks=0,i;
  dsp_accumulator_unit dut(.sys_clk(sys_clk),.nrst(nrst),.op_valid(op_valid),.op_code(op_code),
    .gpr_wdata(gpr_wdata),.mult_result(mult_result),.rd_valid(rd_valid),.rd_data(rd_data),
    .acc_value(acc_value));
  initial forever #12.5 sys_clk=~sys_clk;
  task chk(input string n,input logic [63:0] s,e);
    total_checks++;
    if(s!==e) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h",n,e,s);
    end
  endtask
  function logic [63:0] nx(input logic [3:0] c,input logic [63:0] a,r,input logic [31:0] g);
    case(c)
      1,2,3,4,5: return r;
      6: return {g,a[31:0]};
      7: return {a[63:32],g};
      default: return a;
    endcase
  endfunction
  task finish_test;
    $display("checks %0d bad %0d",total_checks,bad_count);
    if(bad_count==0&&total_checks>0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    x=$urandom(32'hd76521d9);
    repeat(4) @(negedge sys_clk);
    nrst=1;
    chk("acc_init",acc_value,64'h0);
    for(i=0;i<400;i++) begin
      // mid-run reset: everything back to zero, first op straight after release
      if(i==200) begin
        nrst=0;
        op_valid=0;
        @(negedge sys_clk);
        chk("acc_rst",acc_value,64'h0);
        chk("rdv_rst",{63'h0,rd_valid},64'h0);
        chk("rdd_rst",{32'h0,rd_data},64'h0);
        nrst=1;
        m=0;
      end
      // first pass walks every code, refused ones included, with all-ones data
      op_valid=(i<16)||($urandom%4!=0);
      op_code=(i<16)?i[3:0]:4'($urandom%11);
      gpr_wdata=(i<16)?32'hffffffff:$urandom;
      mult_result={$urandom,$urandom};
      @(negedge sys_clk);
      chk("rd_valid",rd_valid,op_valid&&(op_code==8||op_code==9));
      if(rd_valid===1'b1) chk("rd_data",rd_data,(op_code==8)?m[63:32]:m[47:16]);
      if(op_valid) m=nx(op_code,m,mult_result,gpr_wdata);
      chk("acc",acc_value,m);
    end
    finish_test;
  end
endmodule // testbench
`default_nettype wire
